/* File: nested_irq_priority_control.v */
// Software priority arbiter and register slave of a nested interrupt unit
`timescale 1ns/1ps
`include "nested_irq_regs.vh"

// Overview of operation
// - Four 8-bit priority registers at indices 1Ch to 1Fh hold pairs.
// - All priority registers reset to all ones, highest level.
// - Upper nibble of the fourth register reads one, ignores writes.
// - Vector x pair sits in register x/4, bits 2*(x mod 4)+1:+0.
// - Stored pairs use the condition-code level encoding.
// - Writing a pair as lowest level leaves that pair unchanged.
// - Reset and trap load the highest level when serviced.
// - Raised level on a pending serviced vector re-enters it.
// - Vector addresses fixed: reset FFFEh, trap FFFCh, n at FFFAh-2n.
// - Fixed order: reset, trap, then vector 0 down to vector 13.
// - Only reset, ports, serial peripheral and time base leave halt.
// - Slots 2, 8, 9, 12, 13 have no source but keep pairs.
// - Levels: 10 main, 01 one, 00 two, 11 disabled.
// - Maskable vector served only if enabled and above current level.
// - Highest software level wins; ties go by fixed order.
// - Entry loads the current level with the served vector's pair.
module nested_irq_priority_control (
	input wire ref_clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output wire [31:0] prdata,
	input wire [13:0] irq_req,
	input wire [13:0] irq_enable,
	input wire trap_req,
	input wire current_level_high_bit,
	input wire current_level_low_bit,
	input wire cpu_halted,
	input wire cpu_boundary,
	input wire return_from_interrupt,
	output reg irq_grant_q,
	output reg [15:0] vector_addr_q,
	output reg [1:0] new_level_q,
	output reg [3:0] grant_id_q,
	output wire halt_wake
);

	// One-hot grant states
	localparam ST_IDLE = 3'b001;
	localparam ST_GRANT = 3'b010;
	localparam ST_WAIT = 3'b100;

	// Order of level encodings, lowest to highest
	function [1:0] level_rank;
		input [1:0] pair;
		begin
			case (pair)
				`LVL_MAIN: level_rank = 2'd0;
				`LVL_ONE: level_rank = 2'd1;
				`LVL_TWO: level_rank = 2'd2;
				default: level_rank = 2'd3;
			endcase
		end
	endfunction

	// Fixed address of maskable vector n
	function [15:0] vec_addr;
		input [3:0] n;
		begin
			vec_addr = `ADDR_VEC0 - {11'h000, n, 1'b0};
		end
	endfunction

	// Register index from an APB byte address
	function [7:0] reg_index;
		input [31:0] addr;
		begin
			reg_index = addr[9:2];
		end
	endfunction

	// Stored pair of vector n
	function [1:0] pair_of;
		input [31:0] flat;
		input [3:0] n;
		begin
			pair_of = flat[2*n+1 -: 2];
		end
	endfunction

	// One bit of a per-vector mask
	function bit_of;
		input [13:0] mask;
		input [3:0] n;
		begin
			bit_of = mask[n];
		end
	endfunction

	wire [31:0] prio_flat;
	wire [7:0] prio_rd;
	wire [7:0] idx;
	wire hit_prio;
	wire hit_status;
	wire mapped;
	wire setup;
	wire access;
	wire [1:0] cur_level;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg reset_pend_q;
	reg in_service_q;
	reg [3:0] active_q;
	reg [1:0] active_level_q;
	reg [31:0] rdata_q;
	reg rd_is_status_q;
	reg rd_err_q;

	reg cand_valid;
	reg [3:0] cand_id;
	reg [1:0] cand_level;
	reg [15:0] cand_addr;
	reg [1:0] best_rank;
	reg found;
	reg [13:0] eligible;
	reg [1:0] pair;
	reg [1:0] pair_e;
	integer v;
	integer w;

	assign cur_level = {current_level_high_bit, current_level_low_bit};

	// APB decode
	assign idx = reg_index(paddr);
	assign hit_prio = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000) &&
		(idx >= `IDX_PRIO_0) && (idx <= `IDX_PRIO_3);
	assign hit_status = (paddr[1:0] == 2'b00) &&
		(paddr[31:10] == 22'h000000) && (idx == `IDX_STATUS);
	assign mapped = hit_prio || (hit_status && !pwrite);
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = 1'b1;
	assign pslverr = access && rd_err_q;
	assign prdata = rdata_q;

	// Priority register file
	irq_priority_regs u_regs (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(access && pwrite && hit_prio),
		.wr_sel(idx[1:0]),
		.wr_data(pwdata[7:0]),
		.rd_en(setup && !pwrite && hit_prio),
		.rd_sel(idx[1:0]),
		.rd_data_q(prio_rd),
		.prio_flat(prio_flat)
	);

	// Eligibility of each maskable vector
	always @* begin
		eligible = 14'h0000;
		pair_e = 2'b00;
		for (w = 0; w < `NUM_VEC; w = w + 1) begin
			pair_e = pair_of(prio_flat, w[3:0]);
			// Pair compared in the condition-code encoding
			if (irq_req[w] && irq_enable[w] && bit_of(`SRC_PRESENT, w[3:0]) &&
				level_rank(pair_e) > level_rank(cur_level)) begin
				eligible[w] = 1'b1;
			end
			// Halt leaves only the wake-capable sources
			if (cpu_halted && !bit_of(`SRC_WAKE, w[3:0])) begin
				eligible[w] = 1'b0;
			end
			// A raised pair on a still pending active vector re-enters it
			// because it now beats the running level
		end
	end

	// Pick highest level, lowest index on ties
	always @* begin
		found = 1'b0;
		best_rank = 2'd0;
		cand_id = 4'h0;
		pair = 2'b00;
		for (v = `NUM_VEC - 1; v >= 0; v = v - 1) begin
			pair = pair_of(prio_flat, v[3:0]);
			if (eligible[v] && (!found || level_rank(pair) >= best_rank)) begin
				found = 1'b1;
				best_rank = level_rank(pair);
				cand_id = v[3:0];
			end
		end
		cand_valid = found;
		cand_level = pair_of(prio_flat, cand_id);
		cand_addr = vec_addr(cand_id);
		if (trap_req && !cpu_halted) begin
			cand_valid = 1'b1;
			cand_id = `VEC_ID_TRAP;
			cand_level = `LVL_DISABLE;
			cand_addr = `ADDR_TRAP;
		end
		if (reset_pend_q) begin
			cand_valid = 1'b1;
			cand_id = `VEC_ID_RESET;
			cand_level = `LVL_DISABLE;
			cand_addr = `ADDR_RESET;
		end
	end

	// Wake request while halted
	assign halt_wake = cpu_halted && (reset_pend_q || (|eligible));

	// Grant sequencing
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cpu_boundary && cand_valid && !cpu_halted) begin
					state_d = ST_GRANT;
				end
			end
			ST_GRANT: begin
				state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (!cpu_boundary) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Grant pulse lasts one cycle; vector, level and id outputs held until the next grant
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			irq_grant_q <= 1'b0;
			vector_addr_q <= 16'h0000;
			new_level_q <= 2'b11;
			grant_id_q <= 4'h0;
			reset_pend_q <= 1'b1;
			in_service_q <= 1'b0;
			active_q <= 4'h0;
			active_level_q <= 2'b11;
		end else begin
			state_q <= state_d;
			irq_grant_q <= 1'b0;
			if (state_q == ST_IDLE && state_d == ST_GRANT) begin
				irq_grant_q <= 1'b1;
				vector_addr_q <= cand_addr;
				new_level_q <= cand_level;
				grant_id_q <= cand_id;
				active_q <= cand_id;
				active_level_q <= cand_level;
				in_service_q <= 1'b1;
				if (cand_id == `VEC_ID_RESET) begin
					reset_pend_q <= 1'b0;
				end
			end else if (return_from_interrupt) begin
				in_service_q <= 1'b0;
			end
		end
	end

	// Read select and error flag captured in the setup phase; status data stays live
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_is_status_q <= 1'b0;
			rd_err_q <= 1'b0;
		end else if (setup) begin
			rd_is_status_q <= hit_status;
			rd_err_q <= !mapped;
		end
	end

	// Read data view: status or the captured priority byte
	always @* begin
		rdata_q = 32'h00000000;
		if (rd_is_status_q) begin
			rdata_q[`ST_RESET_PEND] = reset_pend_q;
			rdata_q[`ST_TRAP_PEND] = trap_req;
			rdata_q[`ST_HALTED] = cpu_halted;
			rdata_q[`ST_CAND_VALID] = cand_valid;
			rdata_q[`ST_CAND_ID_LSB +: 4] = cand_id;
			rdata_q[`ST_IN_SERVICE] = in_service_q;
			rdata_q[`ST_IN_SERVICE + 1 +: 2] = active_level_q;
			rdata_q[`ST_ACTIVE_LSB +: 4] = active_q;
		end else if (!rd_err_q) begin
			rdata_q[7:0] = prio_rd;
		end
	end

endmodule // nested_irq_priority_control

/* File: nested_irq_regs.vh */
// Offsets, field layouts, reset values and fixed maps of the priority block
`ifndef NESTED_IRQ_REGS_VH
`define NESTED_IRQ_REGS_VH

// Register indices; the byte address is four times the index
`define IDX_PRIO_0 8'h1c
`define IDX_PRIO_1 8'h1d
`define IDX_PRIO_2 8'h1e
`define IDX_PRIO_3 8'h1f
`define IDX_STATUS 8'h20

// Priority register reset value and fixed-one upper bits of register 3
`define PRIO_RESET 8'hff
`define PRIO3_FIXED_MASK 8'hf0

// Level encodings (high bit, low bit)
`define LVL_MAIN 2'b10
`define LVL_ONE 2'b01
`define LVL_TWO 2'b00
`define LVL_DISABLE 2'b11

// Vector numbering
`define NUM_VEC 14
`define VEC_ID_TRAP 4'he
`define VEC_ID_RESET 4'hf

// Slots that carry a source, and sources able to leave halt
`define SRC_PRESENT 14'h0cfb
`define SRC_WAKE 14'h002b

// Fixed vector addresses
`define ADDR_RESET 16'hfffe
`define ADDR_TRAP 16'hfffc
`define ADDR_VEC0 16'hfffa

// Status register fields
`define ST_RESET_PEND 0
`define ST_TRAP_PEND 1
`define ST_HALTED 2
`define ST_CAND_VALID 3
`define ST_CAND_ID_LSB 4
`define ST_IN_SERVICE 8
`define ST_ACTIVE_LSB 12

`endif

/* File: irq_priority_regs.v */
// Four priority registers with protected lowest-level writes
`timescale 1ns/1ps
`include "nested_irq_regs.vh"

module irq_priority_regs (
	input wire ref_clk,
	input wire rst,
	input wire wr_en,
	input wire [1:0] wr_sel,
	input wire [7:0] wr_data,
	input wire rd_en,
	input wire [1:0] rd_sel,
	output reg [7:0] rd_data_q,
	output wire [31:0] prio_flat
);

	reg [7:0] prio_q [0:3];
	reg [7:0] merged;
	integer i;

	// A pair written as the lowest level keeps its old value
	always @* begin
		merged = prio_q[wr_sel];
		for (i = 0; i < 4; i = i + 1) begin
			if (wr_data[2*i+1 -: 2] != `LVL_MAIN) begin
				merged[2*i+1 -: 2] = wr_data[2*i+1 -: 2];
			end
		end
		if (wr_sel == 2'd3) begin
			merged = merged | `PRIO3_FIXED_MASK;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prio_q[0] <= `PRIO_RESET;
			prio_q[1] <= `PRIO_RESET;
			prio_q[2] <= `PRIO_RESET;
			prio_q[3] <= `PRIO_RESET;
			rd_data_q <= 8'h00;
		end else begin
			if (wr_en) begin
				prio_q[wr_sel] <= merged;
			end
			if (rd_en) begin
				rd_data_q <= prio_q[rd_sel] |
					((rd_sel == 2'd3) ? `PRIO3_FIXED_MASK : 8'h00);
			end
		end
	end

	assign prio_flat = {prio_q[3], prio_q[2], prio_q[1], prio_q[0]};

endmodule // irq_priority_regs

/* File: cpu_core_model.sv */
// CPU core stand-in holding the condition-code level
`timescale 1ns/1ps
module cpu_core_model (
	input logic ref_clk,
	input logic rst,
	input logic irq_grant_q,
	input logic [1:0] new_level_q,
	input logic ret,
	input logic [1:0] ret_lvl,
	output logic [1:0] cc_q,
	output logic boundary_q,
	output logic return_from_interrupt
);
	assign return_from_interrupt = ret;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cc_q <= 2'b11;
			boundary_q <= 1'b1;
		end else begin
			boundary_q <= !irq_grant_q;
			if (irq_grant_q)
				cc_q <= new_level_q;
			else if (ret)
				cc_q <= ret_lvl;
		end
	end
endmodule // cpu_core_model

/* File: nested_irq_sva.sv */
// Port assertions of the priority block
`timescale 1ns/1ps
module nested_irq_sva (
	input logic ref_clk,
	input logic rst,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] paddr,
	input logic pslverr,
	input logic [31:0] prdata,
	input logic [13:0] irq_req,
	input logic [13:0] irq_enable,
	input logic irq_grant_q,
	input logic [15:0] vector_addr_q,
	input logic [1:0] new_level_q,
	input logic [3:0] grant_id_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire acc = psel && penable;
	wire mask = irq_grant_q && grant_id_q < 4'he;
	grant_space_a: assert property (
		irq_grant_q |=> !irq_grant_q [*2]) else $error("grants too close");
	fixed_level_a: assert property (
		irq_grant_q && grant_id_q > 4'hd |-> new_level_q == 2'b11)
		else $error("fixed level wrong");
	vector_map_a: assert property (irq_grant_q |->
		vector_addr_q == (grant_id_q == 4'hf ? 16'hfffe :
		grant_id_q == 4'he ? 16'hfffc : 16'hfffa - 2 * grant_id_q))
		else $error("vector address wrong");
	empty_slot_a: assert property (
		mask |-> (14'h0cfb >> grant_id_q) & 14'h1) else $error("empty slot");
	mask_gate_a: assert property (mask |->
		($past(irq_req & irq_enable) >> grant_id_q) & 14'h1)
		else $error("grant without request");
	lowest_never_a: assert property (
		mask |-> new_level_q != 2'b10) else $error("lowest level stored");
	bus_error_a: assert property (acc && paddr != 32'h80 |->
		pslverr == !(paddr inside {32'h70, 32'h74, 32'h78, 32'h7c}))
		else $error("error response wrong");
	upper_ones_a: assert property (
		acc && !pwrite && paddr == 32'h7c |-> prdata[7:4] == 4'hf)
		else $error("upper bits not one");
endmodule // nested_irq_sva
bind nested_irq_priority_control nested_irq_sva nested_irq_sva_i (.*);

/* File: tb_top.sv */
// Self-checking bench of the priority block
`timescale 1ns/1ps
`include "nested_irq_regs.vh"
module tb_top;
	logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic trap_req = 0, cpu_halted = 0, ret = 0, pready, pslverr;
	logic irq_grant_q, halt_wake, err, seen, wk;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd, x;
	logic [13:0] irq_req = 0, irq_enable = 0;
	logic [1:0] ret_lvl = 0, lv, new_level_q, cc;
	logic [15:0] vector_addr_q;
	logic [3:0] grant_id_q;
	logic [7:0] sh [0:3];
	wire current_level_high_bit = cc[1];
	wire current_level_low_bit = cc[0];
	wire cpu_boundary, return_from_interrupt;
	int fail_count = 0, compares = 0, seed = 6, n, k, e;
	always #20 ref_clk = ~ref_clk;
	nested_irq_priority_control nested_irq_priority_control_i (.*);
	cpu_core_model cpu_core_model_i (.ref_clk, .rst, .irq_grant_q,
		.new_level_q, .ret, .ret_lvl, .cc_q(cc), .boundary_q(cpu_boundary),
		.return_from_interrupt);
	task chk(input logic [31:0] s, input logic [31:0] y);
		compares++;
		if (s !== y) begin
			fail_count++;
			$display("unexpected at %0t seen %h expected %h", $time, s, y);
		end
	endtask
	task summarize;
		$display("fail_count %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wrc(input int r, input logic [7:0] d);
		apb(1, 32'h70 + 4 * r, {24'h0, d});
		chk(32'(err), 0);
		for (int j = 0; j < 8; j += 2)
			if (d[j+:2] != 2'b10)
				sh[r][j+:2] = d[j+:2];
		if (r == 3)
			sh[r][7:4] = 4'hf;
		apb(0, 32'h70 + 4 * r, 0);
		chk(rd, {24'h0, sh[r]});
	endtask
	task wgrant;
		seen = 0;
		for (int i = 0; i < 8 && !seen; i++) begin
			@(posedge ref_clk);
			seen = irq_grant_q;
		end
	endtask
	function automatic int rk(input logic [1:0] p);
		return p == 2'b11 ? 3 : 2 - p[0] - 2 * p[1];
	endfunction
	function automatic int pick();
		int b, br, r;
		b = 16;
		br = rk(lv);
		wk = 0;
		for (int i = 0; i < 14; i++) begin
			r = rk(sh[i / 4][2 * (i % 4) +: 2]);
			if (irq_req[i] && irq_enable[i] && (`SRC_PRESENT >> i) & 1) begin
				if (r > rk(lv))
					wk |= (`SRC_WAKE >> i) & 1;
				if (r > br) begin
					b = i;
					br = r;
				end
			end
		end
		if (trap_req)
			b = 14;
		if (cpu_halted)
			b = 16;
		return b;
	endfunction
	initial begin
		for (k = 0; k < 4; k++)
			sh[k] = 8'hff;
		repeat (4) @(posedge ref_clk);
		rst <= 0;
		wgrant();
		chk({grant_id_q, new_level_q, vector_addr_q}, 22'h3ffffe);
		for (k = 0; k < 5; k++) begin
			apb(0, k < 4 ? 32'h70 + 4 * k : 32'h84, 0);
			chk({err, rd[30:0]}, k < 4 ? 32'hff : 32'h80000000);
		end
		apb(1, 32'h80, 32'hff);
		chk(32'(err), 1);
		wrc(1, 8'hcf);
		wrc(1, 8'h64);
		for (k = 0; k < 60; k++) begin
			wrc($random(seed) & 3, 8'($random(seed)));
			lv = $random(seed);
			@(posedge ref_clk);
			ret <= 1;
			ret_lvl <= lv;
			@(posedge ref_clk);
			ret <= 0;
			irq_req <= $random(seed);
			irq_enable <= $random(seed);
			trap_req <= ($random(seed) & 7) == 0;
			cpu_halted <= ($random(seed) & 3) == 0;
			#1;
			e = pick();
			chk(32'(halt_wake), 32'(cpu_halted & wk));
			wgrant();
			chk(32'(seen), 32'(e < 16));
			x = {e == 14 ? 16'hfffc : 16'hfffa - 16'(2 * e), 10'h0, 4'(e),
				e == 14 ? 2'b11 : sh[e / 4][2 * (e % 4) +: 2]};
			if (seen)
				chk({vector_addr_q, 10'h0, grant_id_q, new_level_q}, x);
			if (e < 16 && !seen)
				summarize();
			irq_req <= 0;
			trap_req <= 0;
			cpu_halted <= 0;
		end
		summarize();
	end
endmodule // tb_top
